// >>> hdl/hesi_pkg.sv
// Constants and command codes for the host event status and interrupt block.
package hesi_pkg;
   localparam int HESI_DATA_W = 32;
   localparam int HESI_CODE_W = 8;
   localparam int HESI_OVR_CNT_W = 2;
   // Command codes on the shared microprocessor bus.
   localparam logic [HESI_CODE_W-1:0] HESI_CMD_STATUS_RD = 8'h03;
   localparam logic [HESI_CODE_W-1:0] HESI_CMD_STATUS_WR = 8'h83;
   // Register offset of the status register (same as its read code).
   localparam logic [HESI_CODE_W-1:0] HESI_STATUS_OFFSET = 8'h03;
   // Reset values.
   localparam logic [HESI_DATA_W-1:0] HESI_STATUS_RESET = 32'h0000_0000;
   localparam logic [HESI_OVR_CNT_W-1:0] HESI_OVR_CNT_RESET = 2'h0;
   // Bit position of the schedule overrun flag within the status register.
   localparam int HESI_SCHED_OVERRUN_BIT = 0;
   // Interrupt output latency after the condition changes, in cycles.
   localparam int HESI_IRQ_LATENCY = 1;
endpackage : hesi_pkg

// >>> hdl/hesi_irq_gate.sv
// Interrupt request gating for the host event status flags.
module hesi_irq_gate
   import hesi_pkg::*;
#(
   parameter int WIDTH = HESI_DATA_W
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Flags and enables.
   input wire logic [WIDTH-1:0] flags_i,
   input wire logic [WIDTH-1:0] enable_i,
   input wire logic global_enable_i,
   // Request.
   output logic irq_o
);
   logic irq_d;
   logic irq_q;

   always_comb begin
      irq_d = global_enable_i && (|(flags_i & enable_i));
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign irq_o = irq_q;

   default clocking gate_cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_irq_raise_when_enabled: assert property (
      (global_enable_i && (|(flags_i & enable_i))) |=> irq_o)
      else $error("Interrupt not raised for an enabled set flag.");

   a_irq_drop_when_idle: assert property (
      (!global_enable_i || ((flags_i & enable_i) == '0)) |=> !irq_o)
      else $error("Interrupt stayed high with nothing enabled set.");
endmodule // hesi_irq_gate

// >>> hdl/hesi_host_event_status.sv
// Host event status register with write-one-to-clear flags and interrupt request.
module hesi_host_event_status
   import hesi_pkg::*;
#(
   parameter int WIDTH = HESI_DATA_W,
   parameter int OVR_BIT = HESI_SCHED_OVERRUN_BIT
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Command port from the microprocessor bus interface.
   input wire logic cmd_valid_i,
   input wire logic [HESI_CODE_W-1:0] cmd_code_i,
   input wire logic [WIDTH-1:0] cmd_wdata_i,
   output logic [WIDTH-1:0] rd_data_o,
   output logic rd_valid_o,
   // Internal event sources.
   input wire logic [WIDTH-1:0] event_i,
   input wire logic sched_overrun_i,
   // Enables held elsewhere in the controller.
   input wire logic [WIDTH-1:0] host_event_enable_i,
   input wire logic global_irq_enable_i,
   // Status and interrupt.
   output logic [WIDTH-1:0] host_event_status_o,
   output logic [HESI_OVR_CNT_W-1:0] sched_overrun_count_o,
   output logic irq_o
);
   logic [WIDTH-1:0] status_d;
   logic [WIDTH-1:0] status_q;
   logic [WIDTH-1:0] set_vec;
   logic [WIDTH-1:0] clr_vec;
   logic [HESI_OVR_CNT_W-1:0] ovr_cnt_d;
   logic [HESI_OVR_CNT_W-1:0] ovr_cnt_q;
   logic [WIDTH-1:0] rd_data_d;
   logic [WIDTH-1:0] rd_data_q;
   logic rd_valid_d;
   logic rd_valid_q;
   logic is_wr;
   logic is_rd;

   function automatic logic cmd_hit(input logic vld, input logic [HESI_CODE_W-1:0] code,
                                    input logic [HESI_CODE_W-1:0] want);
      cmd_hit = vld && (code == want);
   endfunction

   always_comb begin
      is_rd = cmd_hit(cmd_valid_i, cmd_code_i, HESI_CMD_STATUS_RD);
      is_wr = cmd_hit(cmd_valid_i, cmd_code_i, HESI_CMD_STATUS_WR);
   end

   // Status flags: only events set, only a write of ones clears.
   always_comb begin
      set_vec = event_i;
      set_vec[OVR_BIT] = event_i[OVR_BIT] | sched_overrun_i;
      clr_vec = is_wr ? cmd_wdata_i : '0;
      // An event in the same cycle as its clear survives, so it is never lost.
      status_d = (status_q & ~clr_vec) | set_vec;
      ovr_cnt_d = ovr_cnt_q;
      if (sched_overrun_i) begin
         // Counts every overrun, wrapping, even if the flag is already set.
         ovr_cnt_d = ovr_cnt_q + HESI_OVR_CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_q <= HESI_STATUS_RESET;
         ovr_cnt_q <= HESI_OVR_CNT_RESET;
      end else begin
         status_q <= status_d;
         ovr_cnt_q <= ovr_cnt_d;
      end
   end

   // Read return: data is captured the edge the read code is taken.
   always_comb begin
      rd_valid_d = is_rd;
      rd_data_d = is_rd ? status_q : rd_data_q;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= HESI_STATUS_RESET;
      end else begin
         rd_valid_q <= rd_valid_d;
         rd_data_q <= rd_data_d;
      end
   end

   // The request is registered, so the pin lags the flags by one edge but never glitches.
   hesi_irq_gate #(
      .WIDTH(WIDTH)
   ) u_irq_gate (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .flags_i(status_q),
      .enable_i(host_event_enable_i),
      .global_enable_i(global_irq_enable_i),
      .irq_o(irq_o)
   );

   assign rd_data_o = rd_data_q;
   assign rd_valid_o = rd_valid_q;
   assign host_event_status_o = status_q;
   assign sched_overrun_count_o = ovr_cnt_q;

   default clocking main_cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_event_seen;
      event_i != '0;
   endsequence

   sequence s_flags_hold_event;
      (status_q & $past(event_i)) == $past(event_i);
   endsequence

   // A read answers once and then falls; an enabled event reaches the pin two edges on.
   sequence s_read_taken;
      is_rd ##1 !is_rd;
   endsequence

   sequence s_read_answer;
      rd_valid_o ##1 !rd_valid_o;
   endsequence

   sequence s_enabled_event;
      global_irq_enable_i && ((event_i & host_event_enable_i) != '0);
   endsequence

   sequence s_enable_held;
      global_irq_enable_i && $stable(host_event_enable_i);
   endsequence

   a_event_sets_flag: assert property (
      s_event_seen |=> s_flags_hold_event)
      else $error("Event did not set its status flag.");

   a_w1c_exact_clear: assert property (
      (is_wr && event_i == '0 && !sched_overrun_i)
      |=> status_q == ($past(status_q) & ~$past(cmd_wdata_i)))
      else $error("Write did not clear exactly the flags written with one.");

   a_write_never_sets: assert property (
      (is_wr && event_i == '0 && !sched_overrun_i)
      |=> (status_q & ~$past(status_q)) == '0)
      else $error("Software write set a status flag.");

   a_no_self_clear: assert property (
      !is_wr |=> (($past(status_q) & ~status_q) == '0))
      else $error("Status flag cleared without a software write.");

   a_read_returns_status: assert property (
      is_rd |=> (rd_valid_o && rd_data_o == $past(status_q)))
      else $error("Read code did not return the status register.");

   a_read_only_on_code: assert property (
      !is_rd |=> !rd_valid_o)
      else $error("Read data valid without the read code.");

   a_overrun_sets_flag: assert property (
      sched_overrun_i |=> status_q[OVR_BIT])
      else $error("Schedule overrun did not set its flag.");

   a_overrun_counts: assert property (
      sched_overrun_i
      |=> sched_overrun_count_o == $past(sched_overrun_count_o) + HESI_OVR_CNT_W'(1))
      else $error("Schedule overrun count did not advance.");

   a_irq_follows_flags: assert property (
      (global_irq_enable_i && (|(status_q & host_event_enable_i))) ##1 1'b1 |-> irq_o)
      else $error("Interrupt missing for an enabled flag.");

   a_read_single_pulse: assert property (
      s_read_taken |-> s_read_answer)
      else $error("Read valid did not last exactly one cycle.");

   a_read_data_holds: assert property (
      !is_rd |=> $stable(rd_data_o))
      else $error("Read data changed without a read.");

   a_event_raises_irq: assert property (
      s_enabled_event ##1 s_enable_held |=> irq_o)
      else $error("Enabled event did not raise the interrupt two cycles on.");

   a_irq_needs_flag: assert property (
      irq_o |-> $past(global_irq_enable_i) && ($past(status_q & host_event_enable_i) != '0))
      else $error("Interrupt raised with no enabled flag set.");

   a_irq_off_no_global: assert property (
      !global_irq_enable_i |=> !irq_o)
      else $error("Interrupt stayed high after the global enable dropped.");

   a_count_holds: assert property (
      !sched_overrun_i |=> $stable(sched_overrun_count_o))
      else $error("Schedule overrun count moved without an overrun.");

   a_count_wraps: assert property (
      (sched_overrun_i && (sched_overrun_count_o == '1)) |=> (sched_overrun_count_o == '0))
      else $error("Schedule overrun count did not wrap to zero.");

   a_overrun_flag_held: assert property (
      (status_q[OVR_BIT] && !(is_wr && cmd_wdata_i[OVR_BIT])) |=> status_q[OVR_BIT])
      else $error("Schedule overrun flag dropped without a clear.");

   // Codes of neighbouring registers share the bus and must leave these flags alone.
   a_other_code_ignored: assert property (
      (cmd_valid_i && !is_rd && !is_wr && (event_i == '0) && !sched_overrun_i)
      |=> $stable(status_q))
      else $error("An unknown command code changed the status flags.");

   // Catches a stray set path, such as write data reaching the flags outside the set vector.
   a_set_needs_event: assert property (
      ((status_q & ~$past(status_q)) & ~$past(set_vec)) == '0)
      else $error("A status flag rose without an event.");

   // Set wins, so a flag raised in the cycle of its clear is never lost to software.
   a_set_wins_clear: assert property (
      (is_wr && ((event_i & cmd_wdata_i) != '0))
      |=> ((status_q & $past(event_i & cmd_wdata_i)) == $past(event_i & cmd_wdata_i)))
      else $error("An event lost against a clear in the same cycle.");
endmodule // hesi_host_event_status

// >>> tb/hesi_host_model.sv
// Behavioural host processor model driving the status command port.
module hesi_host_model
   import hesi_pkg::*;
(
   // Clock.
   input wire logic core_clk_i,
   // Command port.
   output logic cmd_valid_o,
   output logic [HESI_CODE_W-1:0] cmd_code_o,
   output logic [HESI_DATA_W-1:0] cmd_wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_wdata_o = 32'h0;
   end
   // Idle lines show the inverse of the last value, so stale data never looks valid.
   task automatic cmd(input logic [HESI_CODE_W-1:0] code, input logic [HESI_DATA_W-1:0] d);
      @(posedge core_clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_code_o = code;
      cmd_wdata_o = d;
      @(posedge core_clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_code_o = ~code;
      cmd_wdata_o = ~d;
   endtask
endmodule // hesi_host_model

// >>> tb/testbench.sv
// Self-checking testbench for the host event status block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import hesi_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic gen = 1'b0;
   logic ovr = 1'b0;
   logic [31:0] ev = 32'h0;
   logic [31:0] en = 32'h0;
   logic cv;
   logic rv;
   logic irq;
   logic [7:0] code;
   logic [31:0] wd;
   logic [31:0] rd;
   logic [31:0] st;
   logic [1:0] cnt;
   logic [31:0] q[$];
   logic [31:0] exp_s = 32'h0;
   integer seed = 32'h2489ab57;
   int err_total = 0;
   int checks_done = 0;
   hesi_host_model i_hesi_host_model (.core_clk_i(clk), .cmd_valid_o(cv), .cmd_code_o(code),
      .cmd_wdata_o(wd));
   hesi_host_event_status i_hesi_host_event_status (.core_clk_i(clk), .resetn_i(rstn),
      .cmd_valid_i(cv), .cmd_code_i(code), .cmd_wdata_i(wd), .rd_data_o(rd), .rd_valid_o(rv),
      .event_i(ev), .sched_overrun_i(ovr), .host_event_enable_i(en),
      .global_irq_enable_i(gen), .host_event_status_o(st), .sched_overrun_count_o(cnt),
      .irq_o(irq));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(string n, logic [31:0] seen, logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, want, seen);
      end
   endtask
   task automatic finish_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd_st();
      q.push_back(exp_s);
      i_hesi_host_model.cmd(HESI_CMD_STATUS_RD, $random(seed));
   endtask
   task automatic wr_st(logic [31:0] m);
      i_hesi_host_model.cmd(HESI_CMD_STATUS_WR, m);
      exp_s = exp_s & ~m;
   endtask
   task automatic pulse(logic [31:0] e, logic o);
      @(posedge clk);
      #1;
      ev = e;
      ovr = o;
      @(posedge clk);
      #1;
      ev = 32'h0;
      ovr = 1'b0;
      exp_s = exp_s | e | (32'(o) << HESI_SCHED_OVERRUN_BIT);
   endtask
   // Read answers are matched in issue order against the notes left by the driver.
   always @(posedge clk) begin
      if (rv === 1'b1) begin
         chk("rd_data", rd, q.pop_front());
      end
   end
   initial begin
      #20us;
      err_total++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk("status", st, HESI_STATUS_RESET);
      repeat (3) begin
         pulse($random(seed), 1'b0);
         chk("status", st, exp_s);
         rd_st();
         wr_st($random(seed));
         chk("status", st, exp_s);
         i_hesi_host_model.cmd(8'h02, 32'hffffffff);
         rd_st();
      end
      wr_st(32'hffffffff);
      wr_st(32'hffffffff);
      tick(20);
      chk("status", st, 32'h0);
      pulse(32'h0000_0100, 1'b0);
      tick(20);
      chk("status", st, exp_s);
      repeat (5) pulse(32'h0, 1'b1);
      chk("count", 32'(cnt), 32'h1);
      chk("status", st, exp_s);
      // An event and the clear of its own flag in one cycle: the event must win.
      fork
         pulse(32'h0000_0004, 1'b0);
         i_hesi_host_model.cmd(HESI_CMD_STATUS_WR, 32'h0000_0004);
      join
      chk("status", st, exp_s);
      en = 32'h0000_0020;
      pulse(32'h0000_0020, 1'b0);
      tick(2);
      chk("irq", 32'(irq), 32'h0);
      gen = 1'b1;
      tick(2);
      chk("irq", 32'(irq), 32'h1);
      gen = 1'b0;
      tick(2);
      chk("irq", 32'(irq), 32'h0);
      gen = 1'b1;
      wr_st(32'h0000_0020);
      tick(2);
      chk("irq", 32'(irq), 32'h0);
      rd_st();
      tick(3);
      chk("rd_pending", 32'(q.size()), 32'h0);
      finish_test();
   end
endmodule // testbench
